// File: sim/timer_mode_and_updown_reload_bench.sv
`default_nettype none
module timer_mode_and_updown_reload_bench
    import tmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals and tables
    // ----------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] ack = 2'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic timer_irq;
    logic [NUM_PINS-1:0] pins;
    logic [31:0] seed = 32'h1d;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [29:0] regs [5] = '{IDX_MODE, IDX_TL0, IDX_TL1, IDX_TH0, IDX_TH1};
    logic [29:0] tl_i [2] = '{IDX_TL0, IDX_TL1};
    logic [29:0] th_i [2] = '{IDX_TH0, IDX_TH1};
    int cnt_p [2] = '{PIN_CNT0, PIN_CNT1};
    int gate_p [2] = '{PIN_IRQ_A, PIN_IRQ_B};

    // Short divider keeps the clocked runs brief
    tmr_timers #(.DIV01(8'h02)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_irq_a_pin(pins[PIN_IRQ_A]), .ext_irq_b_pin(pins[PIN_IRQ_B]),
        .first_count_pin(pins[PIN_CNT0]), .second_count_pin(pins[PIN_CNT1]),
        .third_count_pin(pins[PIN_CNT2]), .third_direction_pin(pins[PIN_DIR]),
        .first_irq_ack(ack[0]), .second_irq_ack(ack[1]), .timer_irq(timer_irq)
    );

    tmr_pin_model pm (
        .hclk(hclk),
        .pin_out(pins)
    );

    // 100 MHz clock
    always #5 hclk = ~hclk;

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] add16(input logic [15:0] v, input int n);
        return v + 16'(n);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One single AHB transfer; entered just after a rising edge
    task automatic bus(input logic [29:0] idx, input logic wr, input logic [7:0] d,
                       output logic [31:0] x);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {idx, 2'h0};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        x = hrdata;
    endtask

    task automatic wr(input logic [29:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(idx, 1'b1, d, x);
    endtask

    task automatic rd(input logic [29:0] idx, output logic [7:0] v);
        logic [31:0] x;
        bus(idx, 1'b0, 8'h00, x);
        v = x[7:0];
    endtask

    // Upper 24 bits must read as zero as well
    task automatic rd_chk(input logic [29:0] idx, input logic [7:0] e);
        logic [31:0] x;
        bus(idx, 1'b0, 8'h00, x);
        check(x, {24'h0, e});
    endtask

    // Pulse widths drawn at random; then let the synchroniser settle
    task automatic pulse(input int p, input int n);
        pm.pulse(p, n, 2 + int'(rnd() % 3));
        repeat (5) @(posedge hclk);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] a;
        logic [7:0] b;
        logic [15:0] e;
        int n;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 5; i++) rd_chk(regs[i], 8'h00);
        // Read back random values; an unmapped word ignores writes
        for (int i = 1; i < 5; i++)
        begin
            a = 8'(rnd());
            wr(regs[i], a);
            rd_chk(regs[i], a);
        end
        wr(30'h0000010, 8'h5a);
        rd_chk(30'h0000010, 8'h00);
        wr(IDX_MASK, 8'h07);
        for (int t = 0; t < 2; t++)
        begin
            // Gate low holds the count; near-wrap start lets up to four edges carry into the high byte
            a = 8'(rnd()) | 8'hfc;
            b = 8'(rnd());
            wr(IDX_MODE, 8'h0d << (4 * t));
            wr(tl_i[t], a);
            wr(th_i[t], b);
            pm.set_pin(gate_p[t], 1'b0);
            wr(IDX_RUN, 8'(1 << t));
            pulse(cnt_p[t], 2);
            rd_chk(tl_i[t], a);
            pm.set_pin(gate_p[t], 1'b1);
            n = 1 + int'(rnd() % 4);
            pulse(cnt_p[t], n);
            e = add16({b, a}, n);
            rd_chk(tl_i[t], e[7:0]);
            rd_chk(th_i[t], e[15:8]);
            // Low-byte wrap reloads from high byte and raises the flag
            wr(IDX_MODE, 8'h06 << (4 * t));
            wr(tl_i[t], 8'hff);
            wr(th_i[t], b);
            // A carry out of the earlier steps may have left a flag behind
            wr(IDX_STATUS, 8'h07);
            pulse(cnt_p[t], 1);
            rd_chk(tl_i[t], b);
            rd_chk(IDX_STATUS, 8'(1 << t));
            check({31'h0, timer_irq}, 32'h1);
            ack <= 2'(1 << t);
            @(posedge hclk);
            ack <= 2'h0;
            rd_chk(IDX_STATUS, 8'h00);
            check({31'h0, timer_irq}, 32'h0);
            // Only five prescaler bits carry into the high byte
            wr(IDX_MODE, 8'h04 << (4 * t));
            wr(tl_i[t], 8'(rnd()) | 8'h1f);
            pulse(cnt_p[t], 1);
            rd(tl_i[t], a);
            check({27'h0, a[4:0]}, 32'h0);
            rd_chk(th_i[t], b + 8'h01);
        end
        // Second timer halted keeps its count
        wr(IDX_MODE, 8'h70);
        wr(IDX_TL1, 8'h40);
        pulse(PIN_CNT1, 2);
        rd_chk(IDX_TL1, 8'h40);
        // Split: low byte counts pin edges, high byte on second run bit
        wr(IDX_RUN, 8'h00);
        wr(IDX_MODE, 8'h37);
        wr(IDX_TL0, 8'h10);
        wr(IDX_TH0, 8'hfe);
        wr(IDX_STATUS, 8'h07);
        wr(IDX_RUN, 8'h03);
        pulse(PIN_CNT0, 2);
        wr(IDX_RUN, 8'h00);
        rd_chk(IDX_TL0, 8'h12);
        rd_chk(IDX_STATUS, 8'h02);
        wr(IDX_STATUS, 8'h07);
        // Third timer up: direction ignored without down-count enable
        wr(IDX_RL_LO, 8'h34);
        wr(IDX_RL_HI, 8'h12);
        for (int d = 0; d < 2; d++)
        begin
            wr(IDX_TL2, 8'hff);
            wr(IDX_TH2, 8'hff);
            wr(IDX_CTRL2, d ? 8'h07 : 8'h03);
            pm.set_pin(PIN_DIR, 1'(d));
            pulse(PIN_CNT2, 1);
            rd_chk(IDX_TL2, 8'h34);
            rd_chk(IDX_TH2, 8'h12);
            rd_chk(IDX_CTRL2, d ? 8'h87 : 8'h03);
            rd_chk(IDX_STATUS, 8'h04);
            wr(IDX_MASK, d ? 8'h07 : 8'h03);
            // The mask lands at the edge the write returns on; look one cycle later
            @(posedge hclk);
            check({31'h0, timer_irq}, 32'(d));
            wr(IDX_STATUS, 8'h04);
        end
        // Down: step to the reload value, then wrap to all ones
        pm.set_pin(PIN_DIR, 1'b0);
        wr(IDX_TL2, 8'h35);
        wr(IDX_TH2, 8'h12);
        pulse(PIN_CNT2, 1);
        rd_chk(IDX_TL2, 8'h34);
        rd_chk(IDX_STATUS, 8'h00);
        pulse(PIN_CNT2, 1);
        rd_chk(IDX_TH2, 8'hff);
        rd_chk(IDX_TL2, 8'hff);
        rd_chk(IDX_STATUS, 8'h04);
        rd_chk(IDX_CTRL2, 8'h07);
        // Divided clock: about 62 running cycles give 10 or 11 steps
        wr(IDX_CTRL2, 8'h00);
        wr(IDX_TL2, 8'h00);
        wr(IDX_TH2, 8'h00);
        wr(IDX_CTRL2, 8'h01);
        repeat (60) @(posedge hclk);
        wr(IDX_CTRL2, 8'h00);
        rd(IDX_TL2, a);
        check({31'h0, a inside {8'h0a, 8'h0b}}, 32'h1);
        repeat (12) @(posedge hclk);
        rd_chk(IDX_TL2, a);
        finish_test();
    end
endmodule
`default_nettype wire

// File: sim/tmr_pin_model.sv
`default_nettype none
// Drives the gate, count and direction pins from outside the chip
module tmr_pin_model
    import tmr_pkg::*;
(
    input wire logic hclk,
    output logic [NUM_PINS-1:0] pin_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Count pins idle high, so the first edge seen is a falling one
    initial pin_out = '1;

    // Level change just after an edge, held until told otherwise
    task automatic set_pin(input int p, input logic v);
        @(posedge hclk);
        pin_out[p] <= v;
    endtask

    // Width w in cycles: wide pulses model a slow source; w must outlast the synchroniser
    task automatic pulse(input int p, input int n, input int w);
        repeat (n)
        begin
            @(posedge hclk);
            pin_out[p] <= 1'b0;
            repeat (w) @(posedge hclk);
            pin_out[p] <= 1'b1;
            repeat (w - 1) @(posedge hclk);
        end
    endtask
endmodule
`default_nettype wire

// File: verilog/tmr_pin_sync.sv
`default_nettype none
module tmr_pin_sync
    import tmr_pkg::*;
#(
    parameter int N = NUM_PINS
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [N-1:0] pin_in,
    output logic [N-1:0] level,
    output logic [N-1:0] fall
);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] lvl;
        logic [N-1:0] fall;
    } tmr_sync_s;

    tmr_sync_s st;
    tmr_sync_s next_st;
    logic [N-1:0] settle;

    // --------------------------------------------------------
    // Per-pin filter: only a level seen twice in a row counts
    // --------------------------------------------------------
    for (genvar i = 0; i < N; i++)
    begin : g_bit
        assign settle[i] = (st.s2[i] == st.s3[i]) ? st.s2[i] : st.lvl[i];
    end

    // Chain; the first stage feeds only the second
    always_comb
    begin
        next_st = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.lvl = settle;
        next_st.fall = st.lvl & ~settle;
    end

    // Idle level high so a gated timer is not blocked after reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= '{s1: '1, s2: '1, s3: '1, lvl: '1, fall: '0};
        else
            st <= next_st;
    end

    assign level = st.lvl;
    assign fall = st.fall;

endmodule
`default_nettype wire

// File: verilog/tmr_pkg.sv
`default_nettype none
package tmr_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [29:0] IDX_RUN = 30'h0000088;
    localparam logic [29:0] IDX_MODE = 30'h0000089;
    localparam logic [29:0] IDX_TL0 = 30'h000008a;
    localparam logic [29:0] IDX_TL1 = 30'h000008b;
    localparam logic [29:0] IDX_TH0 = 30'h000008c;
    localparam logic [29:0] IDX_TH1 = 30'h000008d;
    localparam logic [29:0] IDX_CTRL2 = 30'h00000c8;
    localparam logic [29:0] IDX_RL_LO = 30'h00000ca;
    localparam logic [29:0] IDX_RL_HI = 30'h00000cb;
    localparam logic [29:0] IDX_TL2 = 30'h00000cc;
    localparam logic [29:0] IDX_TH2 = 30'h00000cd;
    localparam logic [29:0] IDX_STATUS = 30'h00000d0;
    localparam logic [29:0] IDX_MASK = 30'h00000d1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_SECOND_TIMER_GATE = 7;
    localparam int MODE_SRC1 = 6;
    localparam int MODE_M1_LO = 4;
    localparam int MODE_FIRST_TIMER_GATE = 3;
    localparam int MODE_SRC0 = 2;
    localparam int MODE_M0_LO = 0;
    localparam int RUN_FIRST = 0;
    localparam int RUN_SECOND = 1;
    localparam int CTRL2_RUN = 0;
    localparam int CTRL2_SRC = 1;
    localparam int CTRL2_DOWN_COUNT_ENABLE = 2;
    localparam int CTRL2_EXF = 7;
    localparam int ST_FIRST = 0;
    localparam int ST_SECOND = 1;
    localparam int ST_THIRD = 2;

    // ------------------------------------------------------------
    // Mode encodings of the first two timers
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // ------------------------------------------------------------
    // Pin positions and timing
    // ------------------------------------------------------------
    localparam int PIN_IRQ_A = 0;
    localparam int PIN_IRQ_B = 1;
    localparam int PIN_CNT0 = 2;
    localparam int PIN_CNT1 = 3;
    localparam int PIN_CNT2 = 4;
    localparam int PIN_DIR = 5;
    localparam int NUM_PINS = 6;
    localparam logic [7:0] DIV01_DEFAULT = 8'h0c;
    localparam logic [7:0] DIV2_DEFAULT = 8'h06;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] tl;
        logic [7:0] th;
        logic ovf;
    } tmr_cnt_s;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic run0;
        logic run1;
        logic t2run;
        logic t2src;
        logic down_count_enable;
        logic third_timer_external_flag;
        logic [7:0] tl2;
        logic [7:0] th2;
        logic [7:0] rl_lo;
        logic [7:0] rl_hi;
        logic [2:0] status;
        logic [2:0] mask;
        logic [7:0] div01;
        logic [7:0] div2;
        logic dp_wr;
        logic [29:0] dp_idx;
        logic [31:0] rdata;
    } tmr_state_s;

    localparam tmr_state_s TMR_STATE_RESET = '0;

endpackage
`default_nettype wire

// File: verilog/tmr_timers.sv
// The AHB-Lite slave port was left to the implementer.
`default_nettype none
// Function
// - Second timer gated: counts only with its irq pin high and run set
// - Second timer counts divided clock, or count pin falling edges when selected
// - Second timer modes: 13-bit, 16-bit, 8-bit reload, halt keeping count
// - First timer gated: counts only with its irq pin high and run set
// - First timer counts divided clock, or its count pin falling edges
// - First timer modes: 13-bit, 16-bit, 8-bit reload from high byte
// - Split mode: low byte own counter, high byte on second run and flag
// - Mode register and first two timers' count bytes reset to zero
// - Third timer count is two cascaded bytes forming 16 bits
// - Third timer counts clock divided by six, or count pin falling edges
// - Third timer advances only while its run bit is set
// - Up overflow past all ones sets flag, requests irq, loads reload pair
// - Down: count equal reload pair sets flag and loads all ones
// - Each wrap with down-count enable set toggles external flag, no interrupt
// - Overflows set first/second flags; vectoring clears them
// - 13-bit mode uses only lower five bits of low byte
module tmr_timers
    import tmr_pkg::*;
#(
    parameter logic [7:0] DIV01 = DIV01_DEFAULT,
    parameter logic [7:0] DIV2 = DIV2_DEFAULT
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic first_count_pin,
    input wire logic second_count_pin,
    input wire logic third_count_pin,
    input wire logic third_direction_pin,
    input wire logic first_irq_ack,
    input wire logic second_irq_ack,
    output logic timer_irq
);

    tmr_state_s st;
    tmr_state_s next_st;
    logic [NUM_PINS-1:0] pin_lvl;
    logic [NUM_PINS-1:0] pin_fall;
    logic [1:0] m0;
    logic [1:0] m1;
    logic tick01;
    logic tick2;
    logic in0;
    logic in1;
    logic in2;
    logic th0_in;
    logic up2;
    logic wrap2;
    logic [15:0] cnt2;
    logic [15:0] rl2;
    logic [2:0] set_v;
    logic [2:0] clr_v;
    logic acc;
    tmr_cnt_s r0;
    tmr_cnt_s r1;
    logic [15:0] cnt0_w;

    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    tmr_pin_sync #(.N(NUM_PINS)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in({third_direction_pin, third_count_pin, second_count_pin,
                 first_count_pin, ext_irq_b_pin, ext_irq_a_pin}),
        .level(pin_lvl),
        .fall(pin_fall)
    );

    // ------------------------------------------------------------
    // One step of an 8/13/16-bit counter; split and halt handled outside
    // ------------------------------------------------------------
    function automatic tmr_cnt_s tmr_step(input logic [1:0] m, input logic [7:0] tl,
                                         input logic [7:0] th);
        tmr_cnt_s r;
        r.tl = tl;
        r.th = th;
        r.ovf = 1'b0;
        case (m)
            MODE_13BIT:
            begin
                // Upper three bits stay untouched and play no part
                r.tl = {tl[7:5], 5'(tl[4:0] + 5'h01)};
                if (tl[4:0] == 5'h1f)
                begin
                    r.th = th + 8'h01;
                    r.ovf = (th == 8'hff);
                end
            end
            MODE_16BIT:
            begin
                {r.th, r.tl} = {th, tl} + 16'h0001;
                r.ovf = ({th, tl} == 16'hffff);
            end
            MODE_RELOAD:
            begin
                r.tl = (tl == 8'hff) ? th : tl + 8'h01;
                r.ovf = (tl == 8'hff);
            end
            default:
            begin
                r.ovf = 1'b0;
            end
        endcase
        return r;
    endfunction

    // Register read mux; unmapped indices read zero
    function automatic logic [7:0] tmr_read(input tmr_state_s s, input logic [29:0] idx);
        case (idx)
            IDX_RUN: return {6'h00, s.run1, s.run0};
            IDX_MODE: return s.mode;
            IDX_TL0: return s.tl0;
            IDX_TL1: return s.tl1;
            IDX_TH0: return s.th0;
            IDX_TH1: return s.th1;
            IDX_CTRL2: return {s.third_timer_external_flag, 4'h0, s.down_count_enable, s.t2src, s.t2run};
            IDX_RL_LO: return s.rl_lo;
            IDX_RL_HI: return s.rl_hi;
            IDX_TL2: return s.tl2;
            IDX_TH2: return s.th2;
            IDX_STATUS: return {5'h00, s.status};
            IDX_MASK: return {5'h00, s.mask};
            default: return 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Count enables
    // ------------------------------------------------------------
    assign m0 = st.mode[MODE_M0_LO +: 2];
    assign m1 = st.mode[MODE_M1_LO +: 2];
    assign tick01 = (st.div01 == DIV01 - 8'h01);
    assign tick2 = (st.div2 == DIV2 - 8'h01);
    // Gate pin only matters when the gate bit is set
    assign in0 = st.run0 && (!st.mode[MODE_FIRST_TIMER_GATE] || pin_lvl[PIN_IRQ_A])
                 && (st.mode[MODE_SRC0] ? pin_fall[PIN_CNT0] : tick01);
    assign in1 = st.run1 && (!st.mode[MODE_SECOND_TIMER_GATE] || pin_lvl[PIN_IRQ_B])
                 && (st.mode[MODE_SRC1] ? pin_fall[PIN_CNT1] : tick01);
    // Split high byte is a pure timer borrowing the second run bit
    assign th0_in = (m0 == MODE_SPLIT) && st.run1 && tick01;
    assign in2 = st.t2run && (st.t2src ? pin_fall[PIN_CNT2] : tick2);
    assign up2 = !st.down_count_enable || pin_lvl[PIN_DIR];
    assign cnt2 = {st.th2, st.tl2};
    assign rl2 = {st.rl_hi, st.rl_lo};
    assign wrap2 = up2 ? (cnt2 == 16'hffff) : (cnt2 == rl2);
    assign r0 = tmr_step(m0, st.tl0, st.th0);
    assign r1 = tmr_step(m1, st.tl1, st.th1);
    assign acc = hsel && hready && htrans[1];

    // Event set vector, later merged so a set wins over any clear
    always_comb
    begin
        set_v = 3'h0;
        if (m0 == MODE_SPLIT)
        begin
            set_v[ST_FIRST] = in0 && (st.tl0 == 8'hff);
            set_v[ST_SECOND] = th0_in && (st.th0 == 8'hff);
        end
        else
        begin
            set_v[ST_FIRST] = in0 && r0.ovf;
            // Second timer raises no flag while halted in split mode
            set_v[ST_SECOND] = in1 && r1.ovf && (m1 != MODE_SPLIT);
        end
        set_v[ST_THIRD] = in2 && wrap2;
    end

    // Clear sources: vectoring acknowledge and write-one-to-clear
    always_comb
    begin
        clr_v = {1'b0, second_irq_ack, first_irq_ack};
        if (st.dp_wr && st.dp_idx == IDX_STATUS)
            clr_v = clr_v | hwdata[2:0];
    end

    // ------------------------------------------------------------
    // Next state: counting first, then bus writes take precedence over all but flag sets and the external flag toggle
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.div01 = tick01 ? 8'h00 : st.div01 + 8'h01;
        next_st.div2 = tick2 ? 8'h00 : st.div2 + 8'h01;
        // First timer
        if (m0 == MODE_SPLIT)
        begin
            if (in0)
                next_st.tl0 = st.tl0 + 8'h01;
            if (th0_in)
                next_st.th0 = st.th0 + 8'h01;
        end
        else if (in0)
        begin
            next_st.tl0 = r0.tl;
            next_st.th0 = r0.th;
        end
        // Second timer; halt mode simply never steps
        if (in1 && m1 != MODE_SPLIT)
        begin
            next_st.tl1 = r1.tl;
            next_st.th1 = r1.th;
        end
        // Third timer, up with reload or down to the reload pair
        if (in2)
        begin
            if (up2)
                {next_st.th2, next_st.tl2} = wrap2 ? rl2 : cnt2 + 16'h0001;
            else
                {next_st.th2, next_st.tl2} = wrap2 ? 16'hffff : cnt2 - 16'h0001;
        end
        // Bus address phase: read data is latched now, so hrdata is a flop
        next_st.dp_wr = acc && hwrite && (haddr[1:0] == 2'h0);
        next_st.dp_idx = haddr[31:2];
        if (acc && !hwrite)
            next_st.rdata = (haddr[1:0] == 2'h0) ? {24'h000000, tmr_read(st, haddr[31:2])}
                                                 : 32'h00000000;
        // Bus data phase; a write beats a same-cycle count step
        if (st.dp_wr)
        begin
            case (st.dp_idx)
                IDX_RUN:
                begin
                    next_st.run0 = hwdata[RUN_FIRST];
                    next_st.run1 = hwdata[RUN_SECOND];
                end
                IDX_MODE: next_st.mode = hwdata[7:0];
                IDX_TL0: next_st.tl0 = hwdata[7:0];
                IDX_TL1: next_st.tl1 = hwdata[7:0];
                IDX_TH0: next_st.th0 = hwdata[7:0];
                IDX_TH1: next_st.th1 = hwdata[7:0];
                IDX_CTRL2:
                begin
                    next_st.t2run = hwdata[CTRL2_RUN];
                    next_st.t2src = hwdata[CTRL2_SRC];
                    next_st.down_count_enable = hwdata[CTRL2_DOWN_COUNT_ENABLE];
                    next_st.third_timer_external_flag = hwdata[CTRL2_EXF];
                end
                IDX_RL_LO: next_st.rl_lo = hwdata[7:0];
                IDX_RL_HI: next_st.rl_hi = hwdata[7:0];
                IDX_TL2: next_st.tl2 = hwdata[7:0];
                IDX_TH2: next_st.th2 = hwdata[7:0];
                IDX_MASK: next_st.mask = hwdata[2:0];
                default: next_st.mask = st.mask;
            endcase
        end
        // Toggle applied on top of any written value so no wrap is lost
        if (in2 && wrap2 && st.down_count_enable)
            next_st.third_timer_external_flag = !next_st.third_timer_external_flag;
        next_st.status = (st.status & ~clr_v) | set_v;
    end

    // Whole state resets to zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= TMR_STATE_RESET;
        else
            st <= next_st;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata = st.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // External flag is left out of the mask on purpose
    assign timer_irq = |(st.status & st.mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    gate_hold_a: assert property (
        (st.mode[MODE_FIRST_TIMER_GATE] && !pin_lvl[PIN_IRQ_A] && m0 == MODE_16BIT && !st.dp_wr)
        |=> $stable({st.th0, st.tl0}))
        else $error("gated first timer moved with pin low");
    first_inc_a: assert property (
        (m0 == MODE_16BIT && in0 && !st.dp_wr)
        |=> {st.th0, st.tl0} == $past(cnt0_w) + 16'h0001)
        else $error("first timer 16-bit step wrong");
    split_flag_a: assert property (
        (th0_in && st.th0 == 8'hff && !second_irq_ack) |=> st.status[ST_SECOND])
        else $error("split high byte overflow missed second flag");
    halt_keep_a: assert property (
        (m1 == MODE_SPLIT && !st.dp_wr) |=> $stable({st.th1, st.tl1}))
        else $error("halted second timer changed");
    reload_a: assert property (
        (m1 == MODE_RELOAD && in1 && st.tl1 == 8'hff && !st.dp_wr)
        |=> st.tl1 == $past(st.th1) && st.status[ST_SECOND])
        else $error("second timer reload wrong");
    up_wrap_a: assert property (
        (in2 && up2 && cnt2 == 16'hffff && !st.dp_wr)
        |=> cnt2 == $past(rl2) && st.status[ST_THIRD] ##1 timer_irq || !st.mask[ST_THIRD])
        else $error("third timer overflow handling wrong");
    down_wrap_a: assert property (
        (in2 && !up2 && cnt2 == rl2 && !st.dp_wr) |=> cnt2 == 16'hffff)
        else $error("third timer underflow did not load all ones");
    ext_toggle_a: assert property (
        (in2 && wrap2 && st.down_count_enable && !st.dp_wr) |=> st.third_timer_external_flag != $past(st.third_timer_external_flag))
        else $error("external flag did not toggle");
    run_stop_a: assert property (
        (!st.t2run && !st.dp_wr) [*2] |=> $stable(cnt2))
        else $error("third timer moved while stopped");
    set_wins_a: assert property (
        (set_v[ST_FIRST] && first_irq_ack) |=> st.status[ST_FIRST])
        else $error("flag set lost against clear");

    down_wrap_c: cover property (in2 && !up2 && wrap2);
    split_c: cover property (th0_in && st.th0 == 8'hff);
    irq_c: cover property (!timer_irq ##1 timer_irq);

    // First timer as one 16-bit word for the step check
    assign cnt0_w = {st.th0, st.tl0};

endmodule
`default_nettype wire
